// file: pkg/tals_pkg.sv
// package: constants, field positions and types for the trigger arm and list sequencer
// assumes a single 100 MHz clock and an AXI4-Lite register port
package tals_pkg;
	localparam int CLK_MHZ = 100;
	localparam int TICK_US = 1;
	localparam int US_CYC = TICK_US * CLK_MHZ;
	localparam int CH_N = 2;
	localparam int CNT_W = 20;
	localparam int FW = 32;
	localparam int LIST_MAX = 128;
	localparam int DW_W = 30;
	localparam logic [29:0] DWELL_MIN_US = 30'h0000_0001;
	localparam logic [29:0] DWELL_MAX_US = 30'h3B9A_CA00;
	localparam logic [29:0] DWELL_RST_US = 30'h000F_4240;
	localparam logic [31:0] FREQ_RST0 = 32'h0000_0064;
	localparam logic [31:0] FREQ_RST1 = 32'h0000_03E8;
	localparam logic [31:0] FREQ_RST2 = 32'h0000_0226;
	localparam logic [7:0] LIST_RST_N = 8'h03;
	// error -213 in two's complement
	localparam logic [15:0] ERR_INIT_IGN = 16'hFF2B;
	localparam logic [1:0] CONT_RST = 2'h3;
	localparam logic [CNT_W-1:0] TCNT_RST = 20'h00001;
	localparam logic [11:0] OFS_CTRL = 12'h000;
	localparam logic [11:0] OFS_CONT = 12'h004;
	localparam logic [11:0] OFS_SRC = 12'h008;
	localparam logic [11:0] OFS_TCNT0 = 12'h00C;
	localparam logic [11:0] OFS_TCNT1 = 12'h010;
	localparam logic [11:0] OFS_STAT = 12'h014;
	localparam logic [11:0] OFS_FMODE = 12'h018;
	localparam logic [11:0] OFS_DWELL = 12'h01C;
	localparam logic [11:0] OFS_TSTART = 12'h020;
	localparam logic [11:0] OFS_TDATA = 12'h024;
	localparam logic [11:0] OFS_LSTAT = 12'h028;
	localparam logic [11:0] OFS_FREQ = 12'h02C;
	localparam int B_ARM = 0;
	localparam int B_ABORT = 2;
	localparam int B_SWTRG = 4;
	localparam int B_ERR = 4;
	localparam int B_LIST = 0;
	localparam int B_EXTPOL = 1;
	localparam int B_ECODE = 16;
	localparam int B_LIDX = 16;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_SLV = 2'h2;
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_ACT} tals_st_e;
	typedef enum logic [1:0] {SRC_IMM, SRC_EXT, SRC_BUS} tals_src_e;
endpackage : tals_pkg

// file: pkg/tals_seq_if.sv
// interface: control and status between the register block and the list sequencer
// assumes both ends run on the same aclk
`timescale 1ns/1ps
interface tals_seq_if;
	logic load_start;
	logic load_wr;
	logic [31:0] load_data;
	logic list_mode;
	logic imm;
	logic adv;
	logic us_tick;
	logic [29:0] dwell_us;
	logic [31:0] freq;
	logic [6:0] index;
	logic [7:0] count;
	modport seq (input load_start, load_wr, load_data, list_mode, imm, adv, us_tick, dwell_us,
		output freq, index, count);
	modport ctl (output load_start, load_wr, load_data, list_mode, imm, adv, us_tick, dwell_us,
		input freq, index, count);
endinterface : tals_seq_if

// file: hw/tals_list_seq.sv
// frequency table, entry count, dwell timer and step pointer
// assumes one-cycle pulses from the register block on the same clock
`timescale 1ns/1ps
module tals_list_seq #(
	parameter int DEPTH = tals_pkg::LIST_MAX
) (
	input wire logic aclk,
	input wire logic aresetn,
	tals_seq_if.seq s
);
	import tals_pkg::*;
	logic [FW-1:0] tab_q [DEPTH];
	logic [6:0] wptr_q;
	logic pend_q;
	logic [7:0] cnt_q;
	logic [6:0] idx_q;
	logic [29:0] dw_q;
	logic [FW-1:0] freq_q;
	wire dwell_end = s.list_mode && s.imm && s.us_tick && (dw_q + 30'h1 >= s.dwell_us);
	wire step = s.list_mode && (s.adv || dwell_end); // [RULE11] [RULE12] [RULE16]
	wire last = ({1'b0, idx_q} + 8'h01 >= cnt_q);
	wire [6:0] idx_nx = last ? 7'h00 : idx_q + 7'h01; // [RULE20]
	wire room = pend_q || (cnt_q < 8'(DEPTH));
	for (genvar e = 0; e < DEPTH; e++) begin : g_ent
		localparam logic [FW-1:0] RV = (e == 0) ? FREQ_RST0 : (e == 1) ? FREQ_RST1 :
			(e == 2) ? FREQ_RST2 : '0;
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				tab_q[e] <= RV; // [RULE17]
			end else if (s.load_wr && room && wptr_q == 7'(e)) begin
				tab_q[e] <= s.load_data; // [RULE13]
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wptr_q <= '0;
			pend_q <= 1'b0;
			cnt_q <= LIST_RST_N;
		end else if (s.load_start) begin
			wptr_q <= '0;
			pend_q <= 1'b1;
		end else if (s.load_wr && room) begin
			// count never drops below one: the old table stays until a value arrives
			cnt_q <= pend_q ? 8'h01 : cnt_q + 8'h01; // [RULE14] [RULE18]
			wptr_q <= wptr_q + 7'h01;
			pend_q <= 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn || s.load_start) begin
			idx_q <= '0;
		end else if (step) begin
			idx_q <= idx_nx;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn || !s.list_mode || !s.imm || step) begin
			dw_q <= '0;
		end else if (s.us_tick) begin
			dw_q <= dw_q + 30'h1;
		end
	end
	// output follows the pointed table entry one cycle late, so a pointer step or a write to that entry moves it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			freq_q <= FREQ_RST0;
		end else begin
			freq_q <= tab_q[idx_q]; // [RULE5]
		end
	end
	assign s.freq = freq_q;
	assign s.index = idx_q;
	assign s.count = cnt_q;
endmodule : tals_list_seq

// file: hw/tals_top.sv
// top: AXI4-Lite registers, two-channel trigger arm machines, external trigger input
// assumes action_done comes from synthesis logic on aclk; ext_trig is an async pin
`timescale 1ns/1ps
// Function
// (RULE1) arm moves idle channel to wait
// (RULE2) arm and continuous apply per channel or both
// (RULE3) trigger in wait starts action; action ignores triggers
// (RULE4) continuous off: idle after count consumed
// (RULE5) output stays as last trigger left it
// (RULE6) continuous flag 1 on, resets on
// (RULE7) host turns continuous off for counted triggers
// (RULE8) arm with continuous on: ignored, error -213
// (RULE9) abort forces idle from any state
// (RULE10) external source: rear pulse is trigger
// (RULE11) list advances on selected trigger source
// (RULE12) list runs only in list mode
// (RULE13) table holds 1 to 128, fully replaced
// (RULE14) entry count equals values just written
// (RULE15) dwell 1 us to 1000 s, resets 1 s
// (RULE16) immediate source steps every dwell time
// (RULE17) reset table: 100, 1000, 550 Hz
// (RULE18) count reads current entries, 1 to 128
// (RULE19) bus trigger command acts as trigger
// (RULE20) after last entry wrap to first
module tals_top #(
	parameter int TCNT_W = tals_pkg::CNT_W
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext_trig,
	input wire logic [1:0] action_done,
	output logic [1:0] trig_fire,
	output logic [31:0] freq_out,
	output logic list_active
);
	import tals_pkg::*;
	tals_seq_if sq ();
	logic awrdy_q, wrdy_q, awf_q, wf_q, bval_q, arrdy_q, rval_q;
	logic [1:0] bresp_q, rresp_q;
	logic [11:0] awa_q;
	logic [31:0] wd_q, rdat_q;
	logic [3:0] ws_q;
	logic [1:0] cont_q;
	logic [3:0] src_q;
	logic [TCNT_W-1:0] tcnt_q [CH_N];
	logic [TCNT_W-1:0] rem_q [CH_N];
	tals_st_e st_q [CH_N];
	logic err_q, list_q, pol_q;
	logic [29:0] dwell_q;
	logic [2:0] ext_s_q;
	logic [6:0] tick_q;
	logic tick_en_q;
	logic [1:0] fire_q;

	// write path: address and data may come in either order
	wire aw_take = s_axi_awvalid && awrdy_q;
	wire w_take = s_axi_wvalid && wrdy_q;
	wire wr_do = awf_q && wf_q && !bval_q;
	wire awf_d = (awf_q || aw_take) && !wr_do;
	wire wf_d = (wf_q || w_take) && !wr_do;
	wire ar_take = s_axi_arvalid && arrdy_q;
	wire [31:0] wmask = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
	wire wsel_ctrl = wr_do && awa_q == OFS_CTRL && ws_q[0];
	wire wsel_cont = wr_do && awa_q == OFS_CONT && ws_q[0];
	wire wsel_src = wr_do && awa_q == OFS_SRC && ws_q[0];
	wire wsel_tc0 = wr_do && awa_q == OFS_TCNT0;
	wire wsel_tc1 = wr_do && awa_q == OFS_TCNT1;
	wire wsel_stat = wr_do && awa_q == OFS_STAT && ws_q[0];
	wire wsel_fmode = wr_do && awa_q == OFS_FMODE && ws_q[0];
	wire wsel_dwell = wr_do && awa_q == OFS_DWELL;
	wire wsel_tstart = wr_do && awa_q == OFS_TSTART;
	wire wsel_tdata = wr_do && awa_q == OFS_TDATA;
	wire w_map = awa_q == OFS_CTRL || awa_q == OFS_CONT || awa_q == OFS_SRC ||
		awa_q == OFS_TCNT0 || awa_q == OFS_TCNT1 || awa_q == OFS_STAT ||
		awa_q == OFS_FMODE || awa_q == OFS_DWELL || awa_q == OFS_TSTART ||
		awa_q == OFS_TDATA;
	wire [1:0] arm = wsel_ctrl ? wd_q[B_ARM+1:B_ARM] : 2'h0; // [RULE2]
	wire [1:0] abort = wsel_ctrl ? wd_q[B_ABORT+1:B_ABORT] : 2'h0;
	wire [1:0] swtrg = wsel_ctrl ? wd_q[B_SWTRG+1:B_SWTRG] : 2'h0; // [RULE19]
	wire [31:0] tc_new = wsel_tc0 ? ((32'(tcnt_q[0]) & ~wmask) | (wd_q & wmask)) :
		((32'(tcnt_q[1]) & ~wmask) | (wd_q & wmask));
	wire [31:0] dw_new = (32'(dwell_q) & ~wmask) | (wd_q & wmask);
	wire [29:0] dw_clip = (dw_new < 32'(DWELL_MIN_US)) ? DWELL_MIN_US :
		(dw_new > 32'(DWELL_MAX_US)) ? DWELL_MAX_US : dw_new[29:0]; // [RULE15]
	// only the second and third synchronizer stages feed the edge detector
	wire ext_lvl = ext_s_q[1] ^ pol_q;
	wire ext_edge = ext_lvl && !(ext_s_q[2] ^ pol_q); // [RULE10]
	wire [1:0] arm_err;
	wire [1:0] accept;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awf_q <= 1'b0;
			wf_q <= 1'b0;
			awrdy_q <= 1'b1;
			wrdy_q <= 1'b1;
		end else begin
			awf_q <= awf_d;
			wf_q <= wf_d;
			awrdy_q <= !awf_d;
			wrdy_q <= !wf_d;
		end
	end
	always_ff @(posedge aclk) begin
		if (aw_take) awa_q <= {s_axi_awaddr[11:2], 2'h0};
		if (w_take) begin
			wd_q <= s_axi_wdata;
			ws_q <= s_axi_wstrb;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bval_q <= 1'b0;
			bresp_q <= RESP_OK;
		end else if (wr_do) begin
			bval_q <= 1'b1;
			bresp_q <= w_map ? RESP_OK : RESP_SLV;
		end else if (s_axi_bready) begin
			bval_q <= 1'b0;
		end
	end

	// read path: one read at a time, answer the cycle after the address
	wire [11:0] ra = {s_axi_araddr[11:2], 2'h0};
	wire [31:0] stat_rd = {ERR_INIT_IGN, 11'h0, err_q, 2'(st_q[1]), 2'(st_q[0])};
	wire r_map = ra <= OFS_FREQ;
	wire [31:0] rd_mux = (ra == OFS_CONT) ? {30'h0, cont_q} :
		(ra == OFS_SRC) ? {28'h0, src_q} :
		(ra == OFS_TCNT0) ? 32'(tcnt_q[0]) :
		(ra == OFS_TCNT1) ? 32'(tcnt_q[1]) :
		(ra == OFS_STAT) ? stat_rd :
		(ra == OFS_FMODE) ? {30'h0, pol_q, list_q} :
		(ra == OFS_DWELL) ? {2'h0, dwell_q} :
		(ra == OFS_LSTAT) ? {9'h0, sq.index, 8'h0, sq.count} : // [RULE18]
		(ra == OFS_FREQ) ? sq.freq : 32'h0;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arrdy_q <= 1'b1;
			rval_q <= 1'b0;
			rdat_q <= '0;
			rresp_q <= RESP_OK;
		end else if (ar_take) begin
			arrdy_q <= 1'b0;
			rval_q <= 1'b1;
			rdat_q <= rd_mux;
			rresp_q <= r_map ? RESP_OK : RESP_SLV;
		end else if (rval_q && s_axi_rready) begin
			arrdy_q <= 1'b1;
			rval_q <= 1'b0;
		end
	end

	// settings
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cont_q <= CONT_RST; // [RULE6]
			src_q <= '0;
			list_q <= 1'b0;
			pol_q <= 1'b0;
			dwell_q <= DWELL_RST_US; // [RULE15]
		end else begin
			if (wsel_cont) cont_q <= wd_q[1:0]; // [RULE2] [RULE6]
			if (wsel_src) src_q <= wd_q[3:0];
			if (wsel_fmode) list_q <= wd_q[B_LIST]; // [RULE12]
			if (wsel_fmode) pol_q <= wd_q[B_EXTPOL];
			if (wsel_dwell) dwell_q <= dw_clip;
		end
	end
	// error flag: a new arm error wins over a same-cycle clear
	always_ff @(posedge aclk) begin
		if (!aresetn) err_q <= 1'b0;
		else err_q <= (err_q && !(wsel_stat && wd_q[B_ERR])) || (|arm_err); // [RULE8]
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_s_q <= '0;
			tick_q <= '0;
			tick_en_q <= 1'b0;
		end else begin
			ext_s_q <= {ext_s_q[1:0], ext_trig};
			tick_en_q <= tick_q == 7'(US_CYC - 1);
			tick_q <= (tick_q == 7'(US_CYC - 1)) ? 7'h00 : tick_q + 7'h01;
		end
	end

	for (genvar g = 0; g < CH_N; g++) begin : g_ch
		wire tals_src_e src = tals_src_e'(src_q[2*g+1:2*g]);
		wire trg = (src == SRC_IMM) || (src == SRC_EXT && ext_edge) ||
			(src == SRC_BUS && swtrg[g]); // [RULE10] [RULE19]
		wire tc_wr = (g == 0) ? wsel_tc0 : wsel_tc1;
		// counted triggers only mean something with continuous off
		assign accept[g] = st_q[g] == ST_WAIT && trg && !abort[g]; // [RULE3] [RULE7]
		assign arm_err[g] = arm[g] && cont_q[g]; // [RULE8]
		always_ff @(posedge aclk) begin
			if (!aresetn) tcnt_q[g] <= TCNT_RST;
			else if (tc_wr) tcnt_q[g] <= (tc_new[TCNT_W-1:0] == '0) ? TCNT_RST : tc_new[TCNT_W-1:0];
		end
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				st_q[g] <= ST_IDLE;
				rem_q[g] <= '0;
				fire_q[g] <= 1'b0;
			end else begin
				fire_q[g] <= accept[g];
				case (st_q[g])
					ST_IDLE: begin
						if (arm[g] && !cont_q[g] && !abort[g]) begin
							st_q[g] <= ST_WAIT; // [RULE1]
							rem_q[g] <= tcnt_q[g];
						end
					end
					ST_WAIT: begin
						if (abort[g]) st_q[g] <= ST_IDLE; // [RULE9]
						else if (accept[g]) begin
							st_q[g] <= ST_ACT; // [RULE3]
							rem_q[g] <= rem_q[g] - 1'b1;
						end
					end
					ST_ACT: begin
						if (abort[g]) st_q[g] <= ST_IDLE; // [RULE9]
						else if (action_done[g]) begin
							st_q[g] <= (cont_q[g] || rem_q[g] != '0) ? ST_WAIT : ST_IDLE; // [RULE4] [RULE6]
						end
					end
					default: st_q[g] <= ST_IDLE;
				endcase
			end
		end
	end

	assign sq.load_start = wsel_tstart;
	assign sq.load_wr = wsel_tdata; // [RULE13] [RULE14]
	assign sq.load_data = wd_q;
	assign sq.list_mode = list_q;
	assign sq.imm = src_q[1:0] == 2'(SRC_IMM); // [RULE16]
	assign sq.adv = accept[0] && src_q[1:0] != 2'(SRC_IMM); // [RULE11]
	assign sq.us_tick = tick_en_q;
	assign sq.dwell_us = dwell_q;
	tals_list_seq #(.DEPTH(LIST_MAX)) u_seq (
		.aclk(aclk),
		.aresetn(aresetn),
		.s(sq)
	);

	assign s_axi_awready = awrdy_q;
	assign s_axi_wready = wrdy_q;
	assign s_axi_bvalid = bval_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arrdy_q;
	assign s_axi_rvalid = rval_q;
	assign s_axi_rdata = rdat_q;
	assign s_axi_rresp = rresp_q;
	assign trig_fire = fire_q;
	assign freq_out = sq.freq;
	assign list_active = list_q;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_arm_to_wait: assert property (st_q[0] == ST_IDLE && arm[0] // [RULE1]
		&& !cont_q[0] && !abort[0]
		|=> st_q[0] == ST_WAIT && rem_q[0] == $past(tcnt_q[0])) else $error("arm missed");
	a_cont_both: assert property (wsel_cont |=> cont_q == $past(wd_q[1:0])) // [RULE2]
		else $error("continuous write lost");
	a_act_ignore: assert property (st_q[1] == ST_ACT && !action_done[1] && !abort[1] // [RULE3]
		|=> st_q[1] == ST_ACT && $stable(rem_q[1])) else $error("action disturbed");
	a_count_idle: assert property (st_q[0] == ST_ACT && action_done[0] && !abort[0] // [RULE4]
		&& !cont_q[0] && rem_q[0] == '0 |=> st_q[0] == ST_IDLE) else $error("count end missed");
	a_freq_hold: assert property (!list_q ##1 !list_q |=> $stable(sq.freq)) // [RULE5] [RULE12]
		else $error("frequency moved");
	a_arm_err: assert property (arm[0] && cont_q[0] && st_q[0] == ST_IDLE // [RULE8]
		|=> err_q && st_q[0] == ST_IDLE) else $error("arm error missed");
	a_abort_idle: assert property (abort[1] |=> st_q[1] == ST_IDLE) // [RULE9]
		else $error("abort ignored");
	a_ext_trig: assert property (st_q[0] == ST_WAIT && src_q[1:0] == 2'(SRC_EXT) // [RULE10]
		&& ext_edge && !abort[0] |=> st_q[0] == ST_ACT && fire_q[0] ##1 !fire_q[0])
		else $error("ext trig");
	a_count_range: assert property (sq.count >= 8'h01 && sq.count <= 8'(LIST_MAX)) // [RULE18]
		else $error("count out of range");
	// any step counts, dwell steps included, so the immediate-source wrap is watched too
	a_list_wrap: assert property (u_seq.step && !sq.load_start // [RULE20]
		&& {1'b0, sq.index} == sq.count - 8'h01 |=> sq.index == 7'h00) else $error("no wrap");
	c_arm: cover property (st_q[0] == ST_IDLE ##1 st_q[0] == ST_WAIT ##[1:50] st_q[0] == ST_ACT);
	c_cnt_done: cover property (st_q[1] == ST_ACT ##1 st_q[1] == ST_IDLE);
	c_wrap: cover property (sq.list_mode && sq.index != 7'h00 ##1 sq.index == 7'h00);
endmodule : tals_top

// file: tb/tals_far_model.sv
// far side: synthesis path that ends each action, and the rear trigger pin
// assumes trig_fire pulses for one aclk cycle per accepted trigger
`timescale 1ns/1ps
module tals_far_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [1:0] trig_fire,
	input wire logic [7:0] done_dly,
	input wire logic ext_req,
	output logic [1:0] action_done,
	output logic ext_trig
);
	logic [7:0] cnt_q [2];
	// pin idles low and is pulsed high, the default polarity
	assign ext_trig = ext_req;
	// action length comes from the bench: short answers promptly, long keeps the action busy
	always_ff @(posedge aclk) begin
		for (int c = 0; c < 2; c++) begin
			if (!aresetn) begin
				cnt_q[c] <= 8'h00;
				action_done[c] <= 1'b0;
			end else begin
				action_done[c] <= (cnt_q[c] == 8'h01);
				if (trig_fire[c]) begin
					cnt_q[c] <= done_dly;
				end else if (cnt_q[c] != 8'h00) begin
					cnt_q[c] <= cnt_q[c] - 8'h01;
				end
			end
		end
	end
endmodule : tals_far_model

// file: tb/trigger_arm_list_sequencer_tb_top.sv
// bench: drives the register bus and trigger pin, judges states and frequencies
// assumes tals_far_model stands on the far side; dwell shortened to a few us
`timescale 1ns/1ps
module trigger_arm_list_sequencer_tb_top;
	import tals_pkg::*;
	logic aclk;
	logic aresetn;
	logic [11:0] awaddr;
	logic awvalid;
	logic awready;
	logic [31:0] wdata;
	logic wvalid;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic [11:0] araddr;
	logic arvalid;
	logic arready;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic ext_req;
	logic ext_trig;
	logic [1:0] action_done;
	logic [1:0] trig_fire;
	logic [31:0] freq_out;
	logic list_active;
	logic [7:0] dly;
	logic [31:0] rdat;
	logic [1:0] resp;
	int num_errors;
	int checked;
	int fires;

	tals_top dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(1'b1), .ext_trig(ext_trig), .action_done(action_done),
		.trig_fire(trig_fire), .freq_out(freq_out), .list_active(list_active)
	);

	tals_far_model far (
		.aclk(aclk), .aresetn(aresetn), .trig_fire(trig_fire), .done_dly(dly),
		.ext_req(ext_req), .action_done(action_done), .ext_trig(ext_trig)
	);

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		if (trig_fire[0] === 1'b1) fires <= fires + 1;
	end

	task automatic stop_test;
		if (num_errors == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h, want %h", $time, got, exp);
		end
	endtask : chk

	task automatic hang;
		num_errors++;
		$display("unexpected at %0t: wait ran out", $time);
		stop_test();
	endtask : hang

	// bready and rready stay high, so any answer is taken at the edge it appears
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		resp = bresp;
		if (n == 100) hang();
	endtask : wr

	task automatic rd(input logic [11:0] a);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		rdat = rdata;
		resp = rresp;
		if (n == 100) hang();
	endtask : rd

	task automatic wait_done;
		int n;
		for (n = 0; n < 300; n++) begin
			@(posedge aclk);
			if (action_done[0] === 1'b1) break;
		end
		if (n == 300) hang();
	endtask : wait_done

	// pulse the rear pin; a trigger is seen if a fire shows within the window
	task automatic ext_hit(input bit exp, input bit wdone);
		int f;
		int n;
		f = fires;
		ext_req <= 1'b1;
		repeat (2) @(posedge aclk);
		ext_req <= 1'b0;
		for (n = 0; n < 30; n++) begin
			@(posedge aclk);
			if (fires != f) break;
		end
		chk(32'(fires - f), {31'h0, exp});
		// an ignored pulse still has to wait out the action already running
		if (wdone) wait_done();
	endtask : ext_hit

	task automatic t_reset;
		logic [11:0] ra [6];
		logic [31:0] re [6];
		ra = '{OFS_CONT, OFS_SRC, OFS_TCNT0, OFS_DWELL, OFS_LSTAT, OFS_FREQ};
		re = '{32'h3, 32'h0, 32'h1, {2'h0, DWELL_RST_US}, 32'h3, FREQ_RST0};
		for (int k = 0; k < 6; k++) begin
			rd(ra[k]);
			chk(rdat, re[k]);
		end
		chk(freq_out, FREQ_RST0);
		rd(12'h030);
		chk({30'h0, resp}, {30'h0, RESP_SLV});
		wr(12'h040, 32'h1);
		chk({30'h0, resp}, {30'h0, RESP_SLV});
	endtask : t_reset

	task automatic t_err;
		wr(OFS_CTRL, 32'h1);
		rd(OFS_STAT);
		chk(rdat, {ERR_INIT_IGN, 16'h0010});
		wr(OFS_STAT, 32'h10);
		rd(OFS_STAT);
		chk(rdat & 32'h1F, 32'h0);
	endtask : t_err

	task automatic t_count;
		dly <= 8'h64;
		wr(OFS_CONT, 32'h0);
		wr(OFS_SRC, 32'h1);
		wr(OFS_TCNT0, 32'h3);
		wr(OFS_FMODE, 32'h0);
		wr(OFS_CTRL, 32'h1);
		rd(OFS_STAT);
		chk(rdat & 32'hF, 32'h1);
		ext_hit(1'b1, 1'b0);
		ext_hit(1'b0, 1'b1);
		rd(OFS_STAT);
		chk(rdat & 32'hF, 32'h1);
		chk(freq_out, FREQ_RST0);
		dly <= 8'h04;
		wr(OFS_FMODE, 32'h1);
		chk({31'h0, list_active}, 32'h1);
		ext_hit(1'b1, 1'b1);
		chk(freq_out, FREQ_RST1);
		ext_hit(1'b1, 1'b1);
		rd(OFS_STAT);
		chk(rdat & 32'hF, 32'h0);
		ext_hit(1'b0, 1'b0);
		chk(freq_out, FREQ_RST2);
	endtask : t_count

	task automatic t_both;
		dly <= 8'hC8;
		wr(OFS_SRC, 32'h9);
		wr(OFS_CTRL, 32'h3);
		rd(OFS_STAT);
		chk(rdat & 32'hF, 32'h5);
		wr(OFS_CTRL, 32'h4);
		rd(OFS_STAT);
		chk(rdat & 32'hF, 32'h4);
		wr(OFS_CTRL, 32'h20);
		chk({30'h0, trig_fire}, 32'h2);
		rd(OFS_STAT);
		chk(rdat & 32'hF, 32'h8);
		wr(OFS_CTRL, 32'h8);
		rd(OFS_STAT);
		chk(rdat & 32'hF, 32'h0);
	endtask : t_both

	// 2 us dwell is 200 cycles; four entries show the wrap within five steps
	task automatic t_dwell;
		logic [31:0] tbl [4];
		logic [31:0] last;
		int n;
		tbl = '{32'h11, 32'h22, 32'h33, 32'h44};
		wr(OFS_DWELL, 32'h0);
		rd(OFS_DWELL);
		chk(rdat, 32'h1);
		wr(OFS_DWELL, 32'h2);
		wr(OFS_TSTART, 32'h0);
		for (int k = 0; k < 4; k++) wr(OFS_TDATA, tbl[k]);
		rd(OFS_LSTAT);
		chk(rdat & 32'hFF, 32'h4);
		rd(OFS_FREQ);
		chk(rdat, tbl[0]);
		wr(OFS_SRC, 32'h0);
		last = freq_out;
		for (int k = 0; k < 5; k++) begin
			for (n = 1; n <= 1000; n++) begin
				@(posedge aclk);
				if (freq_out !== last) break;
			end
			if (n > 1000) hang();
			last = freq_out;
			if (k > 0) chk(32'(n), 32'd200);
			chk(freq_out, tbl[(k + 1) % 4]);
		end
	endtask : t_dwell

	initial begin
		aresetn = 1'b0;
		awaddr = 12'h000;
		awvalid = 1'b0;
		wdata = 32'h0;
		wvalid = 1'b0;
		araddr = 12'h000;
		arvalid = 1'b0;
		ext_req = 1'b0;
		dly = 8'h04;
		fires = 0;
		num_errors = 0;
		checked = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_err();
		t_count();
		t_both();
		t_dwell();
		stop_test();
	end
endmodule : trigger_arm_list_sequencer_tb_top
